// >>> hdl/gpp_pkg.sv
// gpp_pkg: constants for the general purpose io port block
// assumes: apb3 slave with 32-bit data, byte addressed words
package gpp_pkg;

  //--------------------------------------------------------------
  // sizes
  //--------------------------------------------------------------
  localparam int GPP_NUM_PINS = 8;
  localparam int GPP_NUM_VEC  = 7;
  localparam int GPP_VEC_W    = 3;
  localparam int GPP_SENS_W   = 2 * GPP_NUM_VEC;
  localparam int GPP_ADDR_W   = 12;
  localparam int GPP_DATA_W   = 32;

  //--------------------------------------------------------------
  // register byte offsets
  //--------------------------------------------------------------
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_DATA = 12'h000;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_DIR  = 12'h004;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_OPT  = 12'h008;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_SENS = 12'h00C;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_PEND = 12'h010;

  //--------------------------------------------------------------
  // reset values
  //--------------------------------------------------------------
  localparam logic [GPP_NUM_PINS-1:0] GPP_RST_DATA = 8'hFF;
  localparam logic [GPP_NUM_PINS-1:0] GPP_RST_DIR  = 8'h00;
  localparam logic [GPP_NUM_PINS-1:0] GPP_RST_OPT  = 8'h00;
  localparam logic [GPP_SENS_W-1:0]   GPP_RST_SENS = 14'h0000;

  //--------------------------------------------------------------
  // edge sensitivity codes, one 2-bit field per vector
  //--------------------------------------------------------------
  typedef enum logic [1:0] {
    GPP_SENS_FALL_LOW = 2'b00,
    GPP_SENS_RISE     = 2'b01,
    GPP_SENS_FALL     = 2'b10,
    GPP_SENS_BOTH     = 2'b11
  } gpp_sens_t;

  // pin to vector map, 3 bits per pin, 7 = no interrupt capability
  localparam logic [GPP_NUM_PINS*GPP_VEC_W-1:0] GPP_PIN_VEC =
    24'hED2C40;
  localparam logic [GPP_VEC_W-1:0] GPP_VEC_NONE = 3'h7;

endpackage : gpp_pkg

// >>> hdl/gpp_port.sv
// gpp_port: 8-pin general purpose io port with external interrupts
// assumes: apb3 master on i_sys_clk, pad logic resolves pin from
// o_pin_out/o_pin_oe/o_pin_pullup, cpu gives vector fetch pulses
//
// Summary of operation
// - eight pins, each set by software as input or output.
// - bit x of direction, latch and option registers steers pin x.
// - direction zero makes input; data read returns sampled pin level.
// - latch writes in input mode store only, pin stays undriven.
// - option bit in input mode selects floating or pull-up.
// - option set on capable input pin makes it an interrupt source.
// - edge sensitivity selectable per vector by control register.
// - up to seven vectors, several pins may share one.
// - shared pins are ANDed before edge detection; one low masks others.
// - vector fetch clears that vector's pending request.
// - changing a vector's sensitivity bits clears its pending request.
// - direction one makes output driven from the data latch.
// - data read in output mode returns the latch, not the pin.
// - option bit in output mode selects open-drain or push-pull.
// - latch 0 drives low; latch 1 drives high or releases (open-drain).
// - peripheral alternate output forces output and overrides port.
// - under alternate drive data reg returns the alternate output, not the pin.
// - direction/option pairs: 00 float, 01 pull-up, 10 od, 11 pp.
// - request reaches cpu only if configured and global mask clear.
// - input pin with alternate output enabled reads alternate state.
`timescale 1ns/1ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter int                               NUM_PINS = GPP_NUM_PINS,
  parameter int                               NUM_VEC  = GPP_NUM_VEC,
  parameter logic [GPP_NUM_PINS*GPP_VEC_W-1:0] PIN_VEC = GPP_PIN_VEC
) (
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [GPP_ADDR_W-1:0] i_paddr,
  input  wire logic [GPP_DATA_W-1:0] i_pwdata,
  output logic      [GPP_DATA_W-1:0] o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // pins
  input  wire logic [NUM_PINS-1:0]   i_pin_in,
  output logic      [NUM_PINS-1:0]   o_pin_out,
  output logic      [NUM_PINS-1:0]   o_pin_oe,
  output logic      [NUM_PINS-1:0]   o_pin_pullup,
  // peripheral alternate functions
  input  wire logic [NUM_PINS-1:0]   i_alt_oe,
  input  wire logic [NUM_PINS-1:0]   i_alt_out,
  output logic      [NUM_PINS-1:0]   o_alt_in,
  // cpu interrupt side
  input  wire logic                  i_cpu_int_mask,
  input  wire logic [NUM_VEC-1:0]    i_vec_fetch,
  output logic      [NUM_VEC-1:0]    o_ext_irq
);

  //--------------------------------------------------------------
  // reset release
  //--------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync_r <= 2'b00;
    else          rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  //--------------------------------------------------------------
  // pin input synchroniser
  //--------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_meta_r;
  logic [NUM_PINS-1:0] pin_sync_r;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= i_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  //--------------------------------------------------------------
  // apb decode
  //--------------------------------------------------------------
  logic                  setup;
  logic                  wr_en;
  logic                  hit_data;
  logic                  hit_dir;
  logic                  hit_opt;
  logic                  hit_sens;
  logic                  hit_pend;
  logic                  mapped;

  assign setup    = i_psel & ~i_penable;
  assign wr_en    = i_psel & i_penable & i_pwrite;
  assign hit_data = (i_paddr == GPP_OFS_DATA);
  assign hit_dir  = (i_paddr == GPP_OFS_DIR);
  assign hit_opt  = (i_paddr == GPP_OFS_OPT);
  assign hit_sens = (i_paddr == GPP_OFS_SENS);
  assign hit_pend = (i_paddr == GPP_OFS_PEND);
  assign mapped   = hit_data | hit_dir | hit_opt | hit_sens | hit_pend;

  //--------------------------------------------------------------
  // configuration registers
  //--------------------------------------------------------------
  logic [NUM_PINS-1:0]   latch_r;
  logic [NUM_PINS-1:0]   dir_r;
  logic [NUM_PINS-1:0]   opt_r;
  logic [GPP_SENS_W-1:0] sens_r;
  logic [GPP_SENS_W-1:0] sens_nxt;

  assign sens_nxt = i_pwdata[GPP_SENS_W-1:0];

  // latch writes store even in input mode; pin drive gated by dir
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= GPP_RST_DATA;
      dir_r   <= GPP_RST_DIR;
      opt_r   <= GPP_RST_OPT;
      sens_r  <= GPP_RST_SENS;
    end else begin
      if (wr_en && hit_data) latch_r <= i_pwdata[NUM_PINS-1:0];
      if (wr_en && hit_dir)  dir_r   <= i_pwdata[NUM_PINS-1:0];
      if (wr_en && hit_opt)  opt_r   <= i_pwdata[NUM_PINS-1:0];
      if (wr_en && hit_sens) sens_r  <= sens_nxt;
    end
  end

  //--------------------------------------------------------------
  // pin drive and read-back
  //--------------------------------------------------------------
  logic [NUM_PINS-1:0] out_nxt;
  logic [NUM_PINS-1:0] oe_nxt;
  logic [NUM_PINS-1:0] pull_nxt;
  logic [NUM_PINS-1:0] rd_data;
  logic [NUM_PINS-1:0] od_high;
  logic [NUM_PINS-1:0] pp_mode;

  assign pp_mode = dir_r & opt_r & ~i_alt_oe;
  assign od_high = dir_r & ~opt_r & latch_r & ~i_alt_oe;
  // alternate output wins over port settings
  assign out_nxt = (i_alt_oe & i_alt_out) | (~i_alt_oe & latch_r);
  assign oe_nxt  = i_alt_oe | (dir_r & (opt_r | ~latch_r));
  assign pull_nxt = ~dir_r & opt_r & ~i_alt_oe;
  // read: alternate state, else latch for outputs, pin for inputs
  assign rd_data = (i_alt_oe & i_alt_out)
                 | (~i_alt_oe & dir_r & latch_r)
                 | (~i_alt_oe & ~dir_r & pin_sync_r);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pin_out    <= '0;
      o_pin_oe     <= '0;
      o_pin_pullup <= '0;
      o_alt_in     <= '0;
    end else begin
      o_pin_out    <= out_nxt;
      o_pin_oe     <= oe_nxt;
      o_pin_pullup <= pull_nxt;
      o_alt_in     <= pin_sync_r;
    end
  end

  //--------------------------------------------------------------
  // external interrupt sources
  //--------------------------------------------------------------
  logic [NUM_PINS-1:0] int_en;
  logic [NUM_VEC-1:0]  comb_lvl;
  logic [NUM_VEC-1:0]  prev_lvl_r;
  logic [NUM_VEC-1:0]  evt;
  logic [NUM_VEC-1:0]  sens_chg;
  logic [NUM_VEC-1:0]  pend_r;
  logic [NUM_VEC-1:0]  pend_nxt;

  genvar gp;
  genvar gv;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      // capable pin, input, option set, no alternate drive
      assign int_en[gp] = ~dir_r[gp] & opt_r[gp] & ~i_alt_oe[gp]
                        & (PIN_VEC[gp*GPP_VEC_W +: GPP_VEC_W]
                           != GPP_VEC_NONE);
    end
    for (gv = 0; gv < NUM_VEC; gv++) begin : g_vec
      logic [NUM_PINS-1:0] sel;
      logic [1:0]          mode;
      for (gp = 0; gp < NUM_PINS; gp++) begin : g_sel
        assign sel[gp] = int_en[gp]
          & (PIN_VEC[gp*GPP_VEC_W +: GPP_VEC_W]
             == GPP_VEC_W'(gv));
      end
      // AND of shared pins; idle high when none selected
      assign comb_lvl[gv] = &(pin_sync_r | ~sel);
      assign mode = sens_r[2*gv +: 2];
      // one continuous driver per vector bit; code 00 is low level
      assign evt[gv] =
          (mode == GPP_SENS_RISE) ? (comb_lvl[gv] & ~prev_lvl_r[gv])
        : (mode == GPP_SENS_FALL) ? (~comb_lvl[gv] & prev_lvl_r[gv])
        : (mode == GPP_SENS_BOTH) ? (comb_lvl[gv] ^ prev_lvl_r[gv])
        : ~comb_lvl[gv];
      assign sens_chg[gv] = wr_en & hit_sens
                          & (sens_nxt[2*gv +: 2] != mode);
    end
  endgenerate

  // new event wins over fetch and sensitivity clears
  assign pend_nxt = evt | (pend_r & ~i_vec_fetch & ~sens_chg);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_lvl_r <= '1;
      pend_r     <= '0;
      o_ext_irq  <= '0;
    end else begin
      prev_lvl_r <= comb_lvl;
      pend_r     <= pend_nxt;
      o_ext_irq  <= pend_nxt & {NUM_VEC{~i_cpu_int_mask}};
    end
  end

  //--------------------------------------------------------------
  // apb read data and answer
  //--------------------------------------------------------------
  logic [GPP_DATA_W-1:0] rd_word;

  assign rd_word =
      hit_data ? GPP_DATA_W'(rd_data)
    : hit_dir  ? GPP_DATA_W'(dir_r)
    : hit_opt  ? GPP_DATA_W'(opt_r)
    : hit_sens ? GPP_DATA_W'(sens_r)
    : hit_pend ? GPP_DATA_W'(pend_r)
    : '0;

  // data captured in setup, answered in the first access cycle
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? '0 : rd_word;
      o_pslverr <= ~mapped;
    end
  end
  assign o_pready = 1'b1;

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  sequence s_sens_write;
    wr_en && hit_sens && (sens_chg != '0);
  endsequence

  sequence s_fetch;
    (i_vec_fetch & ~evt) != '0;
  endsequence

  sequence s_data_read;
    setup && hit_data && !i_pwrite;
  endsequence

  a_sync_two_stage: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> pin_sync_r == $past(i_pin_in, 2))
    else $error("pin synchroniser depth wrong");

  a_input_no_drive: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    ((~dir_r & ~i_alt_oe) != '0) |=>
      ((o_pin_oe & $past(~dir_r & ~i_alt_oe)) == '0))
    else $error("input pin is driven");

  a_od_release: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (od_high != '0) |=> ((o_pin_oe & $past(od_high)) == '0))
    else $error("open drain high not released");

  a_pp_drive: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (pp_mode != '0) |=>
      ((o_pin_oe & $past(pp_mode)) == $past(pp_mode)) &&
      ((o_pin_out & $past(pp_mode)) == ($past(latch_r) & $past(pp_mode))))
    else $error("push pull pin not following latch");

  a_alt_override: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (i_alt_oe != '0) |=>
      ((o_pin_oe & $past(i_alt_oe)) == $past(i_alt_oe)) &&
      ((o_pin_out & $past(i_alt_oe))
        == ($past(i_alt_out) & $past(i_alt_oe))))
    else $error("alternate output not forced");

  a_output_readback: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    setup && hit_data && !i_pwrite |=>
      ((o_prdata[NUM_PINS-1:0] & $past(dir_r & ~i_alt_oe))
        == $past(latch_r & dir_r & ~i_alt_oe)))
    else $error("output read does not return latch");

  a_input_readback: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    s_data_read |=>
      ((o_prdata[NUM_PINS-1:0] & $past(~dir_r & ~i_alt_oe))
        == $past(pin_sync_r & ~dir_r & ~i_alt_oe)))
    else $error("input read does not return pin level");

  a_alt_readback: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    s_data_read |=>
      ((o_prdata[NUM_PINS-1:0] & $past(i_alt_oe))
        == $past(i_alt_out & i_alt_oe)))
    else $error("alternate read does not return its output");

  a_pullup_input: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    ##1 (o_pin_pullup & o_pin_oe) == '0)
    else $error("pull-up on a driven pin");

  a_event_sets: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (evt != '0) |=> ((pend_r & $past(evt)) == $past(evt)))
    else $error("event did not set pending");

  a_fetch_clears: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    s_fetch |=> ((pend_r & $past(i_vec_fetch & ~evt)) == '0))
    else $error("vector fetch did not clear pending");

  a_sens_clears: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    s_sens_write |=> ((pend_r & $past(sens_chg & ~evt)) == '0))
    else $error("sensitivity change left pending set");

  a_irq_masked: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    i_cpu_int_mask |=> (o_ext_irq == '0))
    else $error("request passed global mask");

  a_irq_follows: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    !i_cpu_int_mask |=> (o_ext_irq == pend_r))
    else $error("request not shown while unmasked");

endmodule : gpp_port

// >>> tb/gpp_pad_model.sv
// gpp_pad_model: pads and board wiring around the port pins
// assumes: bench sets board drive per pin; port drive wins
`timescale 1ns/1ps
module gpp_pad_model (
  // clock
  input  wire logic       i_sys_clk,
  // port side
  input  wire logic [7:0] i_pin_out,
  input  wire logic [7:0] i_pin_oe,
  input  wire logic [7:0] i_pin_pullup,
  // board side
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  output logic      [7:0] o_pin
);
  // undriven pads wander so no stale level is seen
  logic [7:0] flt_r = 8'h5A;
  always @(posedge i_sys_clk) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_pin_oe[i]) begin
        o_pin[i] = i_pin_out[i];
      end else if (i_ext_en[i]) begin
        o_pin[i] = i_ext_val[i];
      end else if (i_pin_pullup[i]) begin
        o_pin[i] = 1'b1;
      end else begin
        o_pin[i] = flt_r[i];
      end
    end
  end
endmodule : gpp_pad_model

// >>> tb/gpp_port_tb.sv
// gpp_port_tb: self-checking bench for the io port block
// assumes: apb master here, pad model closes the pin loop
`timescale 1ns/1ps
module gpp_port_tb
  import gpp_pkg::*;
();
  typedef struct packed {
    logic [7:0] dir, opt, dat, een, ev, oe, oo, pu, rd;
  } gpp_row_t;
  logic                  clk, rst_n, psel, penable, pwrite;
  logic                  pready, pslverr, int_mask;
  logic [GPP_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, r;
  logic                  e;
  logic [7:0]            pin_in, pin_out, pin_oe, pin_pu;
  logic [7:0]            alt_oe, alt_out, alt_in, ext_en, ext_val;
  logic [6:0]            vec_fetch, ext_irq;
  int                    err_total, samples_checked;
  gpp_row_t rows [5] = '{
    '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hA5, 8'h00, 8'h00, 8'h00, 8'hA5},
    '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF},
    '{8'hFF, 8'hFF, 8'h3C, 8'h00, 8'h00, 8'hFF, 8'h3C, 8'h00, 8'h3C},
    '{8'hFF, 8'h00, 8'h3C, 8'h00, 8'h00, 8'hC3, 8'h00, 8'h00, 8'h3C},
    '{8'hF0, 8'hF0, 8'hA0, 8'h0F, 8'h05, 8'hF0, 8'hA0, 8'h00, 8'hA5}};
  // code, irq after fall, irq after rise
  logic [3:0] sens_tab [4] = '{4'hA, 4'h5, 4'hF, 4'h3};
  logic [11:0] ra [4] = '{GPP_OFS_DIR, GPP_OFS_OPT, GPP_OFS_SENS,
                          GPP_OFS_PEND};

  gpp_port DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pin_in(pin_in), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_pin_pullup(pin_pu), .i_alt_oe(alt_oe),
    .i_alt_out(alt_out), .o_alt_in(alt_in), .i_cpu_int_mask(int_mask),
    .i_vec_fetch(vec_fetch), .o_ext_irq(ext_irq));
  gpp_pad_model pads (.i_sys_clk(clk), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .i_pin_pullup(pin_pu), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pin(pin_in));

  always #10 clk = ~clk;

  //--------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("FAIL t=%0t got %0h exp %0h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("FAIL t=%0t no pready", $time);
      err_total++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pin_drive(input logic [7:0] en, input logic [7:0] v);
    @(posedge clk);
    ext_en  <= en;
    ext_val <= v;
    repeat (6) @(posedge clk);
  endtask : pin_drive

  task automatic fetch;
    @(posedge clk);
    vec_fetch <= 7'h01;
    @(posedge clk);
    vec_fetch <= 7'h00;
    repeat (2) @(posedge clk);
  endtask : fetch

  //--------------------------------------------------------------
  // main sequence
  //--------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, int_mask} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {alt_oe, alt_out, ext_en, ext_val} = 32'h0;
    vec_fetch = 7'h00;
    err_total = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    chk({24'h0, pin_oe}, 32'h0);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(r, 32'h0);
    end
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, GPP_OFS_PEND, 32'h7F);
    chk({31'h0, e}, 32'h0);
    apb(1'b1, GPP_OFS_DIR, 32'hFF);
    apb(1'b0, GPP_OFS_DATA, 32'h0);
    chk(r, 32'hFF);
    foreach (rows[i]) begin
      apb(1'b1, GPP_OFS_DIR, {24'h0, rows[i].dir});
      apb(1'b1, GPP_OFS_OPT, {24'h0, rows[i].opt});
      apb(1'b1, GPP_OFS_DATA, {24'h0, rows[i].dat});
      pin_drive(rows[i].een, rows[i].ev);
      chk({24'h0, pin_oe}, {24'h0, rows[i].oe});
      chk({24'h0, pin_out & pin_oe}, {24'h0, rows[i].oo});
      chk({24'h0, pin_pu}, {24'h0, rows[i].pu});
      chk({24'h0, alt_in & rows[i].een}, {24'h0, rows[i].ev});
      apb(1'b0, GPP_OFS_DATA, 32'h0);
      chk(r, {24'h0, rows[i].rd});
    end
    // alternate output on pins 0 and 7 over an input setting
    apb(1'b1, GPP_OFS_DIR, 32'h0);
    apb(1'b1, GPP_OFS_OPT, 32'h0);
    @(posedge clk);
    alt_oe  <= 8'h81;
    alt_out <= 8'h01;
    pin_drive(8'h00, 8'h00);
    chk({24'h0, pin_oe & 8'h81}, 32'h81);
    chk({24'h0, pin_out & 8'h81}, 32'h01);
    apb(1'b0, GPP_OFS_DATA, 32'h0);
    chk(r & 32'h81, 32'h01);
    @(posedge clk);
    alt_oe <= 8'h00;
    // every sensitivity code on vector 0 through pin 1
    apb(1'b1, GPP_OFS_OPT, 32'h02);
    pin_drive(8'h02, 8'h02);
    foreach (sens_tab[i]) begin
      apb(1'b1, GPP_OFS_SENS, {30'h0, sens_tab[i][3:2]});
      fetch();
      pin_drive(8'h02, 8'h00);
      chk({31'h0, ext_irq[0]}, {31'h0, sens_tab[i][1]});
      fetch();
      pin_drive(8'h02, 8'h02);
      chk({31'h0, ext_irq[0]}, {31'h0, sens_tab[i][0]});
      fetch();
    end
    // level requests left by row 1 on vectors 2, 3 and 6
    apb(1'b0, GPP_OFS_PEND, 32'h0);
    chk(r, 32'h4C);
    apb(1'b1, GPP_OFS_SENS, 32'h3FFC);
    apb(1'b0, GPP_OFS_PEND, 32'h0);
    chk(r, 32'h0);
    // masked event stays pending, sensitivity change drops it
    apb(1'b1, GPP_OFS_SENS, 32'h2);
    fetch();
    @(posedge clk);
    int_mask <= 1'b1;
    pin_drive(8'h02, 8'h00);
    chk({31'h0, ext_irq[0]}, 32'h0);
    apb(1'b0, GPP_OFS_PEND, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, GPP_OFS_SENS, 32'h1);
    apb(1'b0, GPP_OFS_PEND, 32'h0);
    chk(r, 32'h0);
    @(posedge clk);
    int_mask <= 1'b0;
    // pin 0 held low hides a fall on pin 1 of the same vector
    apb(1'b1, GPP_OFS_OPT, 32'h03);
    pin_drive(8'h03, 8'h02);
    apb(1'b1, GPP_OFS_SENS, 32'h2);
    fetch();
    pin_drive(8'h03, 8'h00);
    chk({31'h0, ext_irq[0]}, 32'h0);
    // reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({24'h0, pin_pu}, 32'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, GPP_OFS_OPT, 32'h0);
    chk(r, 32'h0);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    $display("FAIL t=%0t run too long", $time);
    err_total++;
    final_report();
  end
endmodule : gpp_port_tb
